// ---- logic/plc_pkg.sv ----
/*
 Shared constants for the protection lock command block: opcodes, field positions,
 reset values and timing counts. Assumes a 125 MHz system clock on both ends.
*/
`default_nettype none
package plc_pkg;
	localparam logic [7:0] CMD_LOCK_BIT_CLEAR = 8'hA6;
	localparam logic [7:0] CMD_FREEZE_SET = 8'h91;
	localparam logic [7:0] CMD_PASSWORD_READ = 8'hE7;
	localparam logic [7:0] CMD_LOCK_REG_READ = 8'hA7;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam int OPCODE_BITS = 8;
	localparam int PASSWORD_BITS = 64;
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] CNT_OPCODE = CNT_W'(OPCODE_BITS);
	localparam logic [CNT_W-1:0] CNT_WRAP = CNT_W'(OPCODE_BITS + PASSWORD_BITS - 1);
	localparam int LOCK_FREEZE_BIT = 7;
	localparam int LOCK_FLAG_BIT = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_LATCH_BIT = 1;
	localparam int PMODE_PASSWORD_BIT = 2;
	localparam logic LOCK_FLAG_RST = 1'b1;
	localparam logic FREEZE_RST = 1'b0;
	localparam int SYS_CLK_MHZ = 125;
	localparam int OP_TIME_NS = 1000;
	localparam int OP_CYCLES = (OP_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int HOST_HALF_PERIOD = 4;
	localparam int HOST_GAP_CYCLES = 4;
	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_CLEAR = 2'b01,
		OP_FREEZE = 2'b10
	} plc_op_e;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_WEN = 3'b001,
		H_GAP = 3'b010,
		H_XFER = 3'b011,
		H_END = 3'b100
	} plc_host_e;
endpackage
`default_nettype wire

// ---- logic/plc_link_if.sv ----
/*
 Serial link between host controller and flash command logic.
 Assumes the bench instantiates it once and hands the two modports to the two ends.
*/
`default_nettype none
interface plc_link_if;
	logic sck;
	logic ce_n;
	logic si;
	logic so;
	logic so_oe_n;
	logic so_line;
	// Undriven output line reads high, like a pulled-up pin
	assign so_line = so_oe_n ? 1'b1 : so;
	modport device(input sck, input ce_n, input si, output so, output so_oe_n);
	modport host(output sck, output ce_n, output si, input so_line);
endinterface
`default_nettype wire

// ---- logic/plc_sync2.sv ----
/*
 Two flip-flop synchroniser for levels and quasi-static words.
 Assumes multi-bit inputs are stable for several destination clocks before use.
*/
`default_nettype none
module plc_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk)
	begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule
`default_nettype wire

// ---- logic/plc_device.sv ----
/*
 Flash-side command logic: write enable, lock bit clear, freeze set, password,
 lock register and status reads. Link logic runs on the serial clock; the
 self-timed operations run on sys_clk.
 Assumes the user-side inputs belong to sys_clk and that the serial clock
 stands still while chip enable is high.
*/
`default_nettype none
module plc_device
	import plc_pkg::*;
#(
	parameter int OP_CYC = OP_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	plc_link_if.device link,
	input wire logic [63:0] password,
	input wire logic password_programmed,
	input wire logic [15:0] protection_mode_register,
	input wire logic quad_instruction_mode,
	output logic protect_bits_lock_flag,
	output logic freeze_flag,
	output logic write_enable_latch,
	output logic write_in_progress
);
	localparam int TW = $clog2(OP_CYC + 1);
	localparam int XW = 8 + 8 + 1 + PASSWORD_BITS;

	logic frame_new_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic over_r;
	logic over_nxt;
	logic so_r;
	logic so_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic [5:0] idx;
	logic [7:0] status_s;
	logic [7:0] lock_s;
	logic pw_ok_s;
	logic [63:0] pw_s;
	logic [7:0] status_byte;
	logic [7:0] lock_byte;
	logic pw_ok;
	logic pw_ok_r;
	logic [9:0] frame_s;
	logic ce_d_r;
	logic ce_d2_r;
	logic go;
	plc_op_e op_r;
	plc_op_e op_nxt;
	logic [TW-1:0] tmr_r;
	logic [TW-1:0] tmr_nxt;
	logic latch_r;
	logic latch_nxt;
	logic busy_r;
	logic busy_nxt;
	logic lock_r;
	logic lock_nxt;
	logic frz_r;
	logic frz_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock domain: opcode capture

	// A high chip enable marks the next rising edge as the start of a frame
	always_ff @(posedge link.sck or posedge link.ce_n)
	begin
		if (link.ce_n)
			frame_new_r <= 1'b1;
		else
			frame_new_r <= 1'b0;
	end

	always_comb
	begin
		if (frame_new_r)
		begin
			cnt_nxt = CNT_W'(1);
			sh_nxt = {7'h00, link.si};
			over_nxt = 1'b0;
		end
		else
		begin
			cnt_nxt = (cnt_r == CNT_WRAP) ? CNT_OPCODE : cnt_r + CNT_W'(1);
			sh_nxt = (cnt_r < CNT_OPCODE) ? {sh_r[6:0], link.si} : sh_r;
			over_nxt = over_r | (cnt_r >= CNT_OPCODE);
		end
	end

	// Counter and opcode are left standing after the frame for sys_clk to read
	always_ff @(posedge link.sck)
	begin
		cnt_r <= cnt_nxt;
		sh_r <= sh_nxt;
		over_r <= over_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock domain: read data

	plc_sync2 #(.W(XW)) u_to_link (
		.clk(link.sck),
		.d({status_byte, lock_byte, pw_ok_r, password}),
		.q({status_s, lock_s, pw_ok_s, pw_s})
	);

	assign idx = 6'(cnt_r - CNT_OPCODE);

	always_comb
	begin
		so_nxt = 1'b1;
		oe_n_nxt = 1'b1;
		if (!frame_new_r && cnt_r >= CNT_OPCODE)
		begin
			case (sh_r)
				CMD_STATUS_READ:
				begin
					oe_n_nxt = 1'b0;
					so_nxt = status_s[~idx[2:0]];
				end
				CMD_LOCK_REG_READ:
				begin
					oe_n_nxt = status_s[STATUS_BUSY_BIT];
					so_nxt = lock_s[~idx[2:0]];
				end
				CMD_PASSWORD_READ:
				begin
					oe_n_nxt = ~pw_ok_s;
					so_nxt = pw_s[{idx[5:3], ~idx[2:0]}];
				end
				default:
				begin
					oe_n_nxt = 1'b1;
					so_nxt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(negedge link.sck or posedge link.ce_n)
	begin
		if (link.ce_n)
		begin
			so_r <= 1'b1;
			oe_n_r <= 1'b1;
		end
		else
		begin
			so_r <= so_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign link.so = so_r;
	assign link.so_oe_n = oe_n_r;

	////////////////////////////////////////////////////////////////////////////////
	// System clock domain: self-timed operations

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[STATUS_BUSY_BIT] = busy_r;
		status_byte[STATUS_LATCH_BIT] = latch_r;
		lock_byte = 8'h00;
		lock_byte[LOCK_FREEZE_BIT] = frz_r;
		lock_byte[LOCK_FLAG_BIT] = lock_r;
		pw_ok = password_programmed & protection_mode_register[PMODE_PASSWORD_BIT]
			& ~quad_instruction_mode & ~busy_r;
	end

	// Opcode and count settle before chip enable rises, so they are safe to
	// sample one cycle after the synchronised rise
	plc_sync2 #(.W(10)) u_to_sys (
		.clk(sys_clk),
		.d({link.ce_n, (cnt_r == CNT_OPCODE) & ~over_r, sh_r}),
		.q(frame_s)
	);

	assign go = ce_d_r & ~ce_d2_r & frame_s[8];

	always_comb
	begin
		op_nxt = op_r;
		tmr_nxt = tmr_r;
		latch_nxt = latch_r;
		lock_nxt = lock_r;
		frz_nxt = frz_r;
		unique case (op_r)
			OP_IDLE:
			begin
				if (go)
				begin
					if (frame_s[7:0] == CMD_WRITE_ENABLE)
						latch_nxt = 1'b1;
					else if (frame_s[7:0] == CMD_LOCK_BIT_CLEAR && latch_r)
					begin
						op_nxt = OP_CLEAR;
						tmr_nxt = TW'(OP_CYC - 1);
					end
					else if (frame_s[7:0] == CMD_FREEZE_SET && latch_r)
					begin
						op_nxt = OP_FREEZE;
						tmr_nxt = TW'(OP_CYC - 1);
					end
				end
			end
			OP_CLEAR, OP_FREEZE:
			begin
				// Frames arriving now are dropped: only status reads get through
				if (tmr_r == TW'(0))
				begin
					if (op_r == OP_CLEAR)
						lock_nxt = 1'b0;
					else
						frz_nxt = 1'b1;
					latch_nxt = 1'b0;
					op_nxt = OP_IDLE;
				end
				else
					tmr_nxt = tmr_r - TW'(1);
			end
			default:
				op_nxt = OP_IDLE;
		endcase
		busy_nxt = (op_nxt != OP_IDLE);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ce_d_r <= 1'b1;
			ce_d2_r <= 1'b1;
			op_r <= OP_IDLE;
			tmr_r <= '0;
			latch_r <= 1'b0;
			busy_r <= 1'b0;
			pw_ok_r <= 1'b0;
			lock_r <= LOCK_FLAG_RST;
			frz_r <= FREEZE_RST;
		end
		else
		begin
			ce_d_r <= frame_s[9];
			ce_d2_r <= ce_d_r;
			op_r <= op_nxt;
			tmr_r <= tmr_nxt;
			latch_r <= latch_nxt;
			busy_r <= busy_nxt;
			// Registered so the synchroniser never sees a gating glitch
			pw_ok_r <= pw_ok;
			lock_r <= lock_nxt;
			frz_r <= frz_nxt;
		end
	end

	assign protect_bits_lock_flag = lock_r;
	assign freeze_flag = frz_r;
	assign write_enable_latch = latch_r;
	assign write_in_progress = busy_r;
endmodule
`default_nettype wire

// ---- logic/plc_host.sv ----
/*
 Host controller end: divides sys_clk into the serial clock, frames commands
 with chip enable and collects read data. Lock clear and freeze are preceded
 by an automatic write enable frame. Assumes one command at a time.
*/
`default_nettype none
module plc_host
	import plc_pkg::*;
#(
	parameter int HALF = HOST_HALF_PERIOD,
	parameter int GAP = HOST_GAP_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	plc_link_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_op,
	input wire logic [3:0] cmd_rd_bytes,
	output logic [63:0] rd_data,
	output logic done
);
	localparam int PW = $clog2(2 * HALF);
	localparam int GW = $clog2(GAP + 1);
	localparam logic [PW-1:0] PH_LAST = PW'(2 * HALF - 1);

	logic so_s;
	plc_host_e st_r;
	plc_host_e st_nxt;
	logic [PW-1:0] ph_r;
	logic [PW-1:0] ph_nxt;
	logic [7:0] bits_r;
	logic [7:0] bits_nxt;
	logic [7:0] len_r;
	logic [7:0] len_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic [7:0] op_r;
	logic [7:0] op_nxt;
	logic [63:0] rx_r;
	logic [63:0] rx_nxt;
	logic [63:0] rd_r;
	logic [63:0] rd_nxt;
	logic [GW-1:0] gap_r;
	logic [GW-1:0] gap_nxt;
	logic sck_r;
	logic sck_nxt;
	logic ce_n_r;
	logic ce_n_nxt;
	logic done_r;
	logic done_nxt;

	plc_sync2 #(.W(1)) u_so_sync (
		.clk(sys_clk),
		.d(link.so_line),
		.q(so_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer and bit engine

	always_comb
	begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		bits_nxt = bits_r;
		len_nxt = len_r;
		tx_nxt = tx_r;
		op_nxt = op_r;
		rx_nxt = rx_r;
		rd_nxt = rd_r;
		gap_nxt = gap_r;
		sck_nxt = 1'b0;
		ce_n_nxt = ce_n_r;
		done_nxt = 1'b0;
		unique case (st_r)
			H_IDLE:
			begin
				if (cmd_valid)
				begin
					op_nxt = cmd_op;
					ph_nxt = '0;
					ce_n_nxt = 1'b0;
					// Password reads always run exactly one password, whatever cmd_rd_bytes asks for
					if (cmd_op == CMD_PASSWORD_READ)
						len_nxt = 8'(OPCODE_BITS + PASSWORD_BITS);
					else
						len_nxt = 8'(OPCODE_BITS) + {1'b0, cmd_rd_bytes, 3'b000};
					if (cmd_op == CMD_LOCK_BIT_CLEAR || cmd_op == CMD_FREEZE_SET)
					begin
						tx_nxt = CMD_WRITE_ENABLE;
						bits_nxt = 8'(OPCODE_BITS);
						st_nxt = H_WEN;
					end
					else
					begin
						tx_nxt = cmd_op;
						bits_nxt = len_nxt;
						st_nxt = H_XFER;
					end
				end
			end
			H_WEN, H_XFER:
			begin
				ph_nxt = (ph_r == PH_LAST) ? '0 : ph_r + PW'(1);
				sck_nxt = (ph_nxt >= PW'(HALF));
				if (ph_r == PH_LAST)
				begin
					// Device output is stable late in the high phase
					rx_nxt = {rx_r[62:0], so_s};
					tx_nxt = {tx_r[6:0], 1'b0};
					bits_nxt = bits_r - 8'(1);
					if (bits_r == 8'(1))
					begin
						ce_n_nxt = 1'b1;
						sck_nxt = 1'b0;
						gap_nxt = GW'(GAP - 1);
						st_nxt = (st_r == H_WEN) ? H_GAP : H_END;
					end
				end
			end
			H_GAP:
			begin
				if (gap_r == '0)
				begin
					tx_nxt = op_r;
					bits_nxt = len_r;
					ph_nxt = '0;
					ce_n_nxt = 1'b0;
					st_nxt = H_XFER;
				end
				else
					gap_nxt = gap_r - GW'(1);
			end
			H_END:
			begin
				if (gap_r == '0)
				begin
					rd_nxt = rx_r;
					done_nxt = 1'b1;
					st_nxt = H_IDLE;
				end
				else
					gap_nxt = gap_r - GW'(1);
			end
			default:
			begin
				ce_n_nxt = 1'b1;
				st_nxt = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			st_r <= H_IDLE;
			ph_r <= '0;
			bits_r <= 8'h00;
			len_r <= 8'h00;
			tx_r <= 8'h00;
			op_r <= 8'h00;
			rx_r <= 64'h0000_0000_0000_0000;
			rd_r <= 64'h0000_0000_0000_0000;
			gap_r <= '0;
			sck_r <= 1'b0;
			ce_n_r <= 1'b1;
			done_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			bits_r <= bits_nxt;
			len_r <= len_nxt;
			tx_r <= tx_nxt;
			op_r <= op_nxt;
			rx_r <= rx_nxt;
			rd_r <= rd_nxt;
			gap_r <= gap_nxt;
			sck_r <= sck_nxt;
			ce_n_r <= ce_n_nxt;
			done_r <= done_nxt;
		end
	end

	assign cmd_ready = (st_r == H_IDLE);
	assign rd_data = rd_r;
	assign done = done_r;
	assign link.sck = sck_r;
	assign link.ce_n = ce_n_r;
	assign link.si = tx_r[7];
endmodule
`default_nettype wire

// ---- verification/plc_link_monitor.sv ----
/*
 Checker for the protection lock link and the device flags.
 Assumes one instance beside the link interface; slow link lines are sampled on sys_clk.
*/
`default_nettype none
module plc_link_monitor #(
	parameter int OP_CYC = 4
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic ce_n,
	input wire logic so,
	input wire logic so_oe_n,
	input wire logic protect_bits_lock_flag,
	input wire logic freeze_flag,
	input wire logic write_enable_latch,
	input wire logic write_in_progress
);
	wire lk = protect_bits_lock_flag;
	wire fz = freeze_flag;
	wire wl = write_enable_latch;
	wire wp = write_in_progress;
	int busy_r;
	int busy_nxt;
	// Length of the current busy span, allowing the sync delay slack of one cycle
	always_comb busy_nxt = wp ? busy_r + 1 : 0;
	always_ff @(posedge sys_clk) busy_r <= sys_rst ? 0 : busy_nxt;
	////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_lock_clear_latch: assert property (
		$fell(lk) |-> $past(wl) && !wl && $fell(wp)) else $error("lock flag cleared wrongly");
	a_freeze_set_latch: assert property (
		$rose(fz) |-> $past(wl) && !wl && $fell(wp)) else $error("freeze set wrongly");
	a_flags_only_end: assert property (
		!$fell(wp) |-> $stable(lk) && $stable(fz)) else $error("flag moved outside op end");
	a_busy_span: assert property (
		$fell(wp) |-> busy_r >= OP_CYC - 1 && busy_r <= OP_CYC + 1) else $error("busy span length");
	a_busy_after_frame: assert property (
		$rose(wp) |-> ce_n && $past(ce_n, 2)) else $error("busy began inside a frame");
	a_latch_end_clear: assert property (
		$fell(wp) |-> !wl) else $error("latch kept after op");
	a_latch_set_idle: assert property (
		$rose(wl) |-> !wp && !$past(wp)) else $error("latch set while busy");
	a_so_on_fall: assert property (
		sck |-> $stable(so)) else $error("output moved while clock high");
	c_busy: cover property ($rose(wp));
	c_freeze: cover property ($rose(fz));
	c_read: cover property ($fell(so_oe_n));
endmodule
`default_nettype wire

// ---- verification/protection_lock_commands_tb_top.sv ----
/*
 Testbench joining host and device ends over the link interface.
 Assumes the design files are compiled first; OP_CYC is set to 600 so that
 reads and a dropped freeze fit inside one busy span.
*/
`default_nettype none
module protection_lock_commands_tb_top
	import plc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OPC = 600;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_ready, done, lk, fz, wl, wp;
	logic [7:0] cmd_op = 8'h00;
	logic [3:0] cmd_rd_bytes = 4'h0;
	logic [63:0] rd_data;
	logic [63:0] password = 64'h0000_0000_0000_0000;
	logic pw_prog = 1'b1;
	logic [15:0] pmode = 16'hffff;
	logic quad = 1'b0;
	logic [31:0] seed = 32'h0000_ccb2;
	int mismatches = 0;
	int check_count = 0;
	plc_link_if link();
	always #4 sys_clk = ~sys_clk;
	plc_host i_plc_host(.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.host),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_rd_bytes(cmd_rd_bytes), .rd_data(rd_data), .done(done));
	plc_device #(.OP_CYC(OPC)) i_plc_device(.sys_clk(sys_clk), .sys_rst(sys_rst),
		.link(link.device), .password(password), .password_programmed(pw_prog),
		.protection_mode_register(pmode), .quad_instruction_mode(quad),
		.protect_bits_lock_flag(lk), .freeze_flag(fz), .write_enable_latch(wl),
		.write_in_progress(wp));
	plc_link_monitor #(.OP_CYC(OPC)) i_plc_link_monitor(.sys_clk(sys_clk),
		.sys_rst(sys_rst), .sck(link.sck), .ce_n(link.ce_n), .so(link.so),
		.so_oe_n(link.so_oe_n), .protect_bits_lock_flag(lk), .freeze_flag(fz),
		.write_enable_latch(wl), .write_in_progress(wp));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Wire order is low byte first, so byte 0 lands in the top of rd_data
	function automatic logic [63:0] pw_order(input logic [63:0] p);
		logic [63:0] r;
		for (int i = 0; i < 8; i++)
			r[63-8*i -: 8] = p[8*i +: 8];
		return r;
	endfunction
	function automatic logic [7:0] lock_byte(input logic l, input logic f);
		return {f, 6'h00, l};
	endfunction
	function automatic logic [7:0] stat(input logic e, input logic b);
		return {6'h00, e, b};
	endfunction
	task automatic results();
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [7:0] op, input logic [3:0] nb);
		int i;
		cmd_op = op;
		cmd_rd_bytes = nb;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			@(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 2000 && done !== 1'b1; i++)
			@(negedge sys_clk);
		chk(64'(done), 64'(1'b1));
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] exp);
		run(op, 4'h1);
		chk(64'(rd_data[7:0]), 64'(exp));
	endtask
	task automatic wait_wp(input logic v);
		int i;
		for (i = 0; i < 800 && wp !== v; i++)
			@(negedge sys_clk);
		chk(64'(wp), 64'(v));
	endtask
	// Two reads and a freeze are squeezed into the busy span; the freeze must be dropped
	task automatic wop(input logic [7:0] op);
		run(op, 4'h0);
		wait_wp(1'b1);
		rd(CMD_STATUS_READ, stat(1'b1, 1'b1));
		rd(CMD_LOCK_REG_READ, 8'hff);
		run(CMD_FREEZE_SET, 4'h0);
		wait_wp(1'b0);
		repeat (2) @(negedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk(64'({lk, fz, wl, wp, cmd_ready, done}), 64'(6'h22));
		rd(CMD_STATUS_READ, stat(1'b0, 1'b0));
		for (int k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			password[31:0] = seed;
			seed = lfsr(seed);
			password[63:32] = seed;
			pmode = seed[15:0];
			pmode[PMODE_PASSWORD_BIT] = (k != 2);
			pw_prog = (k != 1);
			quad = (k == 3);
			repeat (8) @(negedge sys_clk);
			run(CMD_PASSWORD_READ, 4'h8);
			chk(rd_data, k == 0 ? pw_order(password) : 64'hffff_ffff_ffff_ffff);
		end
		pw_prog = 1'b1;
		quad = 1'b0;
		rd(CMD_LOCK_REG_READ, lock_byte(1'b1, 1'b0));
		run(CMD_LOCK_BIT_CLEAR, 4'h1);
		repeat (10) @(negedge sys_clk);
		chk(64'({lk, wl}), 64'(2'h3));
		wop(CMD_LOCK_BIT_CLEAR);
		chk(64'({lk, fz, wl}), 64'(3'h0));
		run(CMD_FREEZE_SET, 4'h1);
		repeat (10) @(negedge sys_clk);
		chk(64'(fz), 64'(1'b0));
		wop(CMD_FREEZE_SET);
		chk(64'({lk, fz, wl}), 64'(3'h2));
		run(CMD_LOCK_REG_READ, 4'hf);
		chk(rd_data, {8{lock_byte(1'b0, 1'b1)}});
		rd(CMD_STATUS_READ, stat(1'b0, 1'b0));
		results();
	end
	initial
	begin
		#300000;
		mismatches++;
		results();
	end
endmodule
`default_nettype wire
